// ---- testbench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, rst_i, serial_clock_pin_i, serial_input_pin_i;
  logic timer_match_i, external_clock_select_i, clock_polarity_select_i;
  logic [1:0] wire_mode_field_i;
  logic ctrl_wr_i, software_clock_strobe_bit_i, clock_pin_toggle_bit_i;
  logic data_wr_i, cnt_wr_i, ovf_clear_i, start_clear_i, rx_ready_i;
  logic data_dir_out_i, clock_dir_out_i;
  logic [7:0] data_wdata_i, serial_shift_register_o, rx_data_o;
  logic [3:0] cnt_wdata_i, counter_o;
  logic counter_overflow_flag_o, start_flag_o, data_out_pin_o;
  logic data_out_oe_n_o, two_wire_data_o, two_wire_data_oe_n_o;
  logic serial_clock_pin_o, serial_clock_oe_n_o, rx_valid_o;
  logic m_sck, m_sck_oe_n, dout_wire;
  logic [7:0] a, b, v, last_cap;
  int fails = 0;
  int tests_run = 0;
  int seed = 32'hD7CF;
  logic [7:0] rxq[$];
  // Both lines carry pull-downs, so a released line reads low.
  assign serial_clock_pin_i = !serial_clock_oe_n_o ? serial_clock_pin_o :
                              !m_sck_oe_n ? m_sck : 1'h0;
  assign dout_wire = data_out_oe_n_o ? 1'h0 : data_out_pin_o;
  usu_unit usu_unit_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .serial_clock_pin_i(serial_clock_pin_i),
    .serial_input_pin_i(serial_input_pin_i), .timer_match_i(timer_match_i),
    .wire_mode_field_i(wire_mode_field_i),
    .external_clock_select_i(external_clock_select_i),
    .clock_polarity_select_i(clock_polarity_select_i),
    .ctrl_wr_i(ctrl_wr_i),
    .software_clock_strobe_bit_i(software_clock_strobe_bit_i),
    .clock_pin_toggle_bit_i(clock_pin_toggle_bit_i), .data_wr_i(data_wr_i),
    .data_wdata_i(data_wdata_i), .cnt_wr_i(cnt_wr_i),
    .cnt_wdata_i(cnt_wdata_i), .ovf_clear_i(ovf_clear_i),
    .start_clear_i(start_clear_i), .data_dir_out_i(data_dir_out_i),
    .clock_dir_out_i(clock_dir_out_i), .rx_ready_i(rx_ready_i),
    .serial_shift_register_o(serial_shift_register_o),
    .counter_o(counter_o), .counter_overflow_flag_o(counter_overflow_flag_o),
    .start_flag_o(start_flag_o), .data_out_pin_o(data_out_pin_o),
    .data_out_oe_n_o(data_out_oe_n_o), .two_wire_data_o(two_wire_data_o),
    .two_wire_data_oe_n_o(two_wire_data_oe_n_o),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_oe_n_o(serial_clock_oe_n_o), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o));
  usu_spi_model usu_spi_model_i (
    .sys_clk_i(sys_clk_i), .sck_wire_i(serial_clock_pin_i),
    .miso_i(dout_wire), .sck_o(m_sck), .sck_oe_n_o(m_sck_oe_n),
    .mosi_o(serial_input_pin_i));
  initial begin
    sys_clk_i = 1'h0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic wr_ctrl(input logic stb, input logic tgl);
    software_clock_strobe_bit_i = stb;
    clock_pin_toggle_bit_i = tgl;
    ctrl_wr_i = 1'h1;
    cyc(1);
    ctrl_wr_i = 1'h0;
  endtask : wr_ctrl
  task automatic wr_data(input logic [7:0] d);
    data_wdata_i = d;
    data_wr_i = 1'h1;
    cyc(1);
    data_wr_i = 1'h0;
  endtask : wr_data
  task automatic wr_cnt(input logic [3:0] d);
    cnt_wdata_i = d;
    cnt_wr_i = 1'h1;
    cyc(1);
    cnt_wr_i = 1'h0;
    cyc(2);
  endtask : wr_cnt
  task automatic clr_ovf;
    ovf_clear_i = 1'h1;
    cyc(1);
    ovf_clear_i = 1'h0;
    cyc(2);
  endtask : clr_ovf
  task automatic strobe_run(input int gap, input logic [7:0] d);
    logic lvl;
    external_clock_select_i = 1'h0;
    clock_polarity_select_i = 1'h0;
    clock_dir_out_i = 1'h1;
    cyc(4);
    lvl = serial_clock_pin_o;
    wr_data(d);
    clr_ovf;
    for (int i = 0; i < 16; i++) begin
      wr_ctrl(i[0], 1'h1);
      if (gap > 2) begin
        cyc(2);
        lvl = ~lvl;
        check({7'h0, serial_clock_pin_o}, {7'h0, lvl});
      end
      cyc(1);
    end
    cyc(2);
    check({4'h0, counter_o}, 8'h08);
  endtask : strobe_run
  task automatic ext_xfer(input logic [1:0] wm, input logic pol);
    a = 8'($random(seed));
    b = 8'($random(seed));
    wire_mode_field_i = wm;
    // A strobe bit left set would make the counter count toggle writes.
    software_clock_strobe_bit_i = 1'h0;
    clock_dir_out_i = 1'h0;
    external_clock_select_i = 1'h1;
    clock_polarity_select_i = pol;
    usu_spi_model_i.set_idle(pol);
    cyc(6);
    wr_data(a);
    clr_ovf;
    // The byte reaches the queue head one cycle after the transfer task returns.
    rxq.push_back(b);
    usu_spi_model_i.master_xfer(b);
    cyc(6);
    check(serial_shift_register_o, b);
    // Only three-wire mode drives data-out; otherwise the pull-down wins.
    v = (wm == 2'h1) ? a : 8'h00;
    check(usu_spi_model_i.rx_byte, v);
    check({7'h0, counter_overflow_flag_o}, 8'h01);
    check({4'h0, counter_o}, 8'h00);
    $display("done transfer mode %0d polarity %0d", wm, pol);
  endtask : ext_xfer
  // Every word leaving the receive queue is matched against the model.
  always @(posedge sys_clk_i) begin
    if (rx_valid_o === 1'h1 && rx_ready_i === 1'h1) begin
      if (rxq.size() == 0) check({7'h0, rx_valid_o}, 8'h00);
      else check(rx_data_o, rxq.pop_front());
    end
  end
  initial begin
    #100us;
    fails++;
    stop_test();
  end
  initial begin
    {rst_i, ctrl_wr_i, data_wr_i, cnt_wr_i, ovf_clear_i} = 5'h10;
    {timer_match_i, software_clock_strobe_bit_i} = 2'h0;
    {clock_pin_toggle_bit_i, start_clear_i, clock_dir_out_i} = 3'h0;
    {external_clock_select_i, clock_polarity_select_i} = 2'h0;
    wire_mode_field_i = 2'h1;
    data_dir_out_i = 1'h1;
    rx_ready_i = 1'h1;
    data_wdata_i = 8'h00;
    cnt_wdata_i = 4'h0;
    cyc(11);
    check(serial_shift_register_o, 8'h00);
    check({3'h0, counter_o, counter_overflow_flag_o}, 8'h00);
    check({6'h0, rx_valid_o, data_out_oe_n_o}, 8'h01);
    cyc(1);
    rst_i = 1'h0;
    cyc(2);
    $display("done reset");
    a = 8'($random(seed));
    data_wdata_i = a;
    data_wr_i = 1'h1;
    wr_ctrl(1'h1, 1'h0);
    data_wr_i = 1'h0;
    cyc(2);
    check(serial_shift_register_o, a);
    clock_polarity_select_i = 1'h1;
    wr_data(a);
    clr_ovf;
    repeat (3) begin
      timer_match_i = 1'h1;
      cyc(1);
      timer_match_i = 1'h0;
      cyc(1);
    end
    cyc(2);
    v = {a[4:0], {3{serial_input_pin_i}}};
    check(serial_shift_register_o, v);
    check({4'h0, counter_o}, 8'h03);
    $display("done timer and collision");
    a = 8'($random(seed));
    b = 8'($random(seed));
    fork
      usu_spi_model_i.slave_xfer(b);
      strobe_run(4, a);
    join
    check(serial_shift_register_o, b);
    check(usu_spi_model_i.rx_byte, a);
    strobe_run(2, a);
    $display("done software clock");
    ext_xfer(2'h1, 1'h0);
    ext_xfer(2'h1, 1'h1);
    ext_xfer(2'h0, 1'h0);
    cyc(8);
    // Two-wire: data falling while the clock is high marks a start.
    wire_mode_field_i = 2'h2;
    usu_spi_model_i.set_idle(1'h1);
    usu_spi_model_i.set_data(1'h1);
    cyc(6);
    usu_spi_model_i.set_data(1'h0);
    cyc(6);
    check({6'h0, start_flag_o, serial_clock_oe_n_o}, 8'h02);
    check({7'h0, serial_clock_pin_o}, 8'h00);
    start_clear_i = 1'h1;
    cyc(1);
    start_clear_i = 1'h0;
    cyc(3);
    check({6'h0, start_flag_o, serial_clock_oe_n_o}, 8'h01);
    external_clock_select_i = 1'h0;
    wr_data(8'h00);
    cyc(3);
    check({6'h0, two_wire_data_oe_n_o, data_out_oe_n_o}, 8'h01);
    wr_data(8'h80);
    cyc(3);
    check({6'h0, two_wire_data_oe_n_o, two_wire_data_o}, 8'h02);
    wire_mode_field_i = 2'h1;
    $display("done two-wire start");
    {clock_dir_out_i, external_clock_select_i} = 2'h0;
    clock_polarity_select_i = 1'h0;
    wr_cnt(4'h9);
    clr_ovf;
    check({4'h0, counter_o}, 8'h00);
    rx_ready_i = 1'h0;
    // Seventeen words fill queue and head; the eighteenth waits.
    for (int i = 0; i < 18; i++) begin
      v = 8'($random(seed));
      wr_data(v);
      wr_cnt(4'hF);
      check({4'h0, counter_o}, 8'h0F);
      wr_ctrl(1'h1, 1'h0);
      cyc(2);
      last_cap = {v[6:0], serial_input_pin_i};
      rxq.push_back(last_cap);
      check({3'h0, counter_o, counter_overflow_flag_o}, 8'h01);
      clr_ovf;
      check({7'h0, counter_overflow_flag_o}, 8'h00);
    end
    wr_ctrl(1'h1, 1'h0);
    cyc(2);
    check(serial_shift_register_o, last_cap);
    check({4'h0, counter_o}, 8'h00);
    for (int i = 0; i < 400 && rxq.size() > 0; i++) begin
      rx_ready_i = 1'($random(seed));
      cyc(1);
    end
    rx_ready_i = 1'h1;
    cyc(4);
    check(8'(rxq.size()), 8'h00);
    $display("done receive queue");
    stop_test();
  end
endmodule : tb_top

// ---- testbench/usu_spi_model.sv ----
module usu_spi_model (
  input wire logic sys_clk_i,
  input wire logic sck_wire_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half of a 200 ns link clock period, in 25 ns system cycles.
  localparam int HALF = 4;
  logic [7:0] rx_byte = 8'h00;
  logic idle_lvl = 1'h0;
  initial begin
    sck_o = 1'h0;
    sck_oe_n_o = 1'h1;
    mosi_o = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : tick
  // The clock rests at the polarity level so both modes see the same
  // first edge as the sampling edge.
  task automatic set_idle(input logic lvl);
    idle_lvl = lvl;
    sck_o = lvl;
    sck_oe_n_o = 1'h0;
  endtask : set_idle
  task automatic set_data(input logic lvl);
    mosi_o = lvl;
  endtask : set_data
  task automatic master_xfer(input logic [7:0] tx);
    mosi_o = tx[7];
    tick(HALF);
    for (int i = 7; i >= 0; i--) begin
      sck_o = ~idle_lvl;
      tick(HALF - 1);
      rx_byte = {rx_byte[6:0], miso_i};
      tick(1);
      sck_o = idle_lvl;
      if (i > 0) mosi_o = tx[i-1];
      tick(HALF);
    end
    // A released line must not keep showing the last bit.
    mosi_o = ~mosi_o;
  endtask : master_xfer
  task automatic slave_xfer(input logic [7:0] tx);
    int n;
    logic last;
    n = 0;
    last = sck_wire_i;
    sck_oe_n_o = 1'h1;
    mosi_o = tx[7];
    while (n < 8) begin
      tick(1);
      if (sck_wire_i && !last) begin
        rx_byte = {rx_byte[6:0], miso_i};
        n++;
      end
      if (!sck_wire_i && last) mosi_o = tx[7 - n];
      last = sck_wire_i;
    end
  endtask : slave_xfer
endmodule : usu_spi_model

// ---- verilog/usu_pkg.sv ----
package usu_pkg;

  // Widths of the shift register and the transfer counter.
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [DATA_W-1:0] SHIFT_RST = 8'h00;
  localparam int MSB = DATA_W - 1;

  // Wire mode field encodings.
  localparam logic [1:0] WM_NONE = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;

  // Receive FIFO shape.
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;

  // Reset levels of the pin drivers: released, with the pin levels low.
  localparam logic PIN_IDLE = 1'h1;
  localparam logic OE_N_OFF = 1'h1;
  localparam logic LOW = 1'h0;

  // System clock period, for reference by timing figures.
  localparam int SYS_CLK_PERIOD_NS = 25;

endpackage : usu_pkg

// ---- verilog/usu_unit.sv ----
module usu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_valid_i,
  output logic s_ready_o,
  input wire logic [WIDTH-1:0] s_data_i,
  output logic m_valid_o,
  input wire logic m_ready_i,
  output logic [WIDTH-1:0] m_data_o
);
  localparam logic [AW:0] FULL_COUNT = AW'(DEPTH) == '0 ? (AW+1)'(DEPTH) :
    (AW+1)'(DEPTH);
  localparam logic [AW:0] ZERO_COUNT = '0;
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic [WIDTH-1:0] dout_reg;
  logic dvalid_reg;
  logic push;
  logic take;

  // The output stage is a register, so the data seen downstream is a flop.
  assign s_ready_o = count_reg != FULL_COUNT;
  assign push = s_valid_i && s_ready_o;
  assign take = (count_reg != ZERO_COUNT) && (!dvalid_reg || m_ready_i);
  assign m_valid_o = dvalid_reg;
  assign m_data_o = dout_reg;

  always_comb begin
    count_next = count_reg;
    if (push && !take) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (take && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= s_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
      end
      if (take) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
      end
      count_reg <= count_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dvalid_reg <= 1'b0;
      dout_reg <= '0;
    end else if (take) begin
      dvalid_reg <= 1'b1;
      dout_reg <= mem[rd_ptr_reg];
    end else if (m_ready_i) begin
      dvalid_reg <= 1'b0;
    end
  end
endmodule : usu_fifo

// Overview of operation
// - Unbuffered 8-bit shift register, directly accessed
// - MSB drives data-out or two-wire data pin
// - Output latch moves output to opposite edge
// - Serial input always from data-input pin
// - Read/write 4-bit counter with overflow flag
// - Shift register and counter share clock
// - External clock: counter counts both edges, or toggle writes with strobe bit set
// - Clock from pin, timer match, software
// - Two-wire start condition raises flag
// - Two-wire holds clock low for waits
// - SPI modes 0/1, no slave select
// - Eight clock periods exchange full bytes
// - Toggle bit write inverts clock pin
// - Polarity zero: sample rising, shift falling
// - Polarity one: sample falling, shift rising
// - Load data and clear counter before clocking
// - Sixteen edges overflow, flag transfer done
// - Overflow flag wakes processor from idle
// - Clearing overflow flag also clears counter
// - Strobe bit shifts and counts per write with internal clock, polarity zero
// - Latch open first half, always internal
// - Data write beats simultaneous shift
// - No wire mode still shifts from pins
module usu_unit (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_input_pin_i,
  input wire logic timer_match_i,
  input wire logic [1:0] wire_mode_field_i,
  input wire logic external_clock_select_i,
  input wire logic clock_polarity_select_i,
  input wire logic ctrl_wr_i,
  input wire logic software_clock_strobe_bit_i,
  input wire logic clock_pin_toggle_bit_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic cnt_wr_i,
  input wire logic [3:0] cnt_wdata_i,
  input wire logic ovf_clear_i,
  input wire logic start_clear_i,
  input wire logic data_dir_out_i,
  input wire logic clock_dir_out_i,
  input wire logic rx_ready_i,
  output logic [7:0] serial_shift_register_o,
  output logic [3:0] counter_o,
  output logic counter_overflow_flag_o,
  output logic start_flag_o,
  output logic data_out_pin_o,
  output logic data_out_oe_n_o,
  output logic two_wire_data_o,
  output logic two_wire_data_oe_n_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_oe_n_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  logic sck_meta_reg;
  logic sck_sync_reg;
  logic sck_prev_reg;
  logic di_meta_reg;
  logic di_sync_reg;
  logic di_prev_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] count_reg;
  logic ovf_flag_reg;
  logic start_flag_reg;
  logic sample_bit_reg;
  logic latch_open_reg;
  logic out_bit_reg;
  logic sck_out_reg;
  logic push_pend_reg;
  logic [7:0] pend_data_reg;
  logic do_reg;
  logic do_oe_n_reg;
  logic sda_oe_n_reg;
  logic sck_pin_reg;
  logic sck_oe_n_reg;
  logic sck_rise;
  logic sck_fall;
  logic sample_edge;
  logic shift_edge;
  logic int_shift;
  logic shift_ev;
  logic cnt_ev;
  logic wrap;
  logic two_wire;
  logic hold_low;
  logic fifo_ready;

  function automatic logic usu_pick(input logic pol, input logic rise,
                                    input logic fall);
    usu_pick = pol ? fall : rise;
  endfunction : usu_pick

  // Both pins come from another domain; only the second and third stages are used.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_meta_reg <= usu_pkg::LOW;
      sck_sync_reg <= usu_pkg::LOW;
      sck_prev_reg <= usu_pkg::LOW;
      di_meta_reg <= usu_pkg::LOW;
      di_sync_reg <= usu_pkg::LOW;
      di_prev_reg <= usu_pkg::LOW;
    end else begin
      sck_meta_reg <= serial_clock_pin_i;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
      di_meta_reg <= serial_input_pin_i;
      di_sync_reg <= di_meta_reg;
      di_prev_reg <= di_sync_reg;
    end
  end

  assign sck_rise = sck_sync_reg && !sck_prev_reg;
  assign sck_fall = !sck_sync_reg && sck_prev_reg;
  // Pin edges are used in every wire mode, including none.
  assign sample_edge = external_clock_select_i &&
    usu_pick(clock_polarity_select_i, sck_rise, sck_fall);
  assign shift_edge = external_clock_select_i &&
    usu_pick(clock_polarity_select_i, sck_fall, sck_rise);
  // Internal sources: polarity bit picks timer match or software strobe.
  assign int_shift = !external_clock_select_i &&
    (clock_polarity_select_i ? timer_match_i
     : (ctrl_wr_i && software_clock_strobe_bit_i));
  // A byte waiting for FIFO space freezes the engine rather than losing it.
  assign shift_ev = (shift_edge || int_shift) && !push_pend_reg;
  always_comb begin
    if (!external_clock_select_i) begin
      cnt_ev = int_shift;
    end else if (software_clock_strobe_bit_i) begin
      cnt_ev = ctrl_wr_i && clock_pin_toggle_bit_i;
    end else begin
      cnt_ev = sck_rise || sck_fall;
    end
    cnt_ev = cnt_ev && !push_pend_reg;
  end
  assign wrap = cnt_ev && (count_reg == usu_pkg::CNT_MAX) && !cnt_wr_i;

  // External mode shifts in the bit caught at the earlier sampling edge.
  always_comb begin
    shift_next = shift_reg;
    if (data_wr_i) begin
      shift_next = data_wdata_i;
    end else if (shift_ev) begin
      shift_next = {shift_reg[usu_pkg::MSB-1:0],
        external_clock_select_i ? sample_bit_reg : di_sync_reg};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= usu_pkg::SHIFT_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_bit_reg <= usu_pkg::LOW;
    end else if (sample_edge) begin
      sample_bit_reg <= di_sync_reg;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= usu_pkg::CNT_RST;
    end else if (cnt_wr_i) begin
      count_reg <= cnt_wdata_i;
    end else if (ovf_clear_i && !cnt_ev) begin
      count_reg <= usu_pkg::CNT_RST;
    end else if (cnt_ev) begin
      count_reg <= count_reg + usu_pkg::CNT_ONE;
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_flag_reg <= usu_pkg::LOW;
    end else if (wrap) begin
      ovf_flag_reg <= 1'b1;
    end else if (ovf_clear_i) begin
      ovf_flag_reg <= usu_pkg::LOW;
    end
  end

  assign two_wire = wire_mode_field_i[1];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_flag_reg <= usu_pkg::LOW;
    end else if (two_wire && sck_sync_reg && !di_sync_reg && di_prev_reg) begin
      start_flag_reg <= 1'b1;
    end else if (start_clear_i) begin
      start_flag_reg <= usu_pkg::LOW;
    end
  end

  // Latch opens at the output-change edge and closes at the sample edge.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_open_reg <= 1'b1;
    end else if (!external_clock_select_i || shift_edge) begin
      latch_open_reg <= 1'b1;
    end else if (sample_edge) begin
      latch_open_reg <= usu_pkg::LOW;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_bit_reg <= usu_pkg::LOW;
    end else if (latch_open_reg || shift_edge || !external_clock_select_i)
    begin
      out_bit_reg <= shift_next[usu_pkg::MSB];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_out_reg <= usu_pkg::LOW;
    end else if (ctrl_wr_i && clock_pin_toggle_bit_i) begin
      sck_out_reg <= !sck_out_reg;
    end
  end

  // Wait states: hold the clock low while a start is pending, or in WM_TWO_HOLD while an overflow is pending.
  assign hold_low = two_wire && (start_flag_reg ||
    (wire_mode_field_i == usu_pkg::WM_TWO_HOLD && ovf_flag_reg));

  // No slave select exists; the data-out driver is enabled by three-wire mode and its direction bit.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      do_reg <= usu_pkg::LOW;
      do_oe_n_reg <= usu_pkg::OE_N_OFF;
      sda_oe_n_reg <= usu_pkg::OE_N_OFF;
      sck_pin_reg <= usu_pkg::LOW;
      sck_oe_n_reg <= usu_pkg::OE_N_OFF;
    end else begin
      do_reg <= out_bit_reg;
      do_oe_n_reg <= !(wire_mode_field_i == usu_pkg::WM_THREE &&
        data_dir_out_i);
      sda_oe_n_reg <= !(two_wire && data_dir_out_i && !out_bit_reg);
      sck_pin_reg <= hold_low ? usu_pkg::LOW : sck_out_reg;
      sck_oe_n_reg <= !(hold_low || clock_dir_out_i);
    end
  end

  // The finished byte is kept aside until the FIFO accepts it.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      push_pend_reg <= usu_pkg::LOW;
      pend_data_reg <= usu_pkg::SHIFT_RST;
    end else if (wrap) begin
      push_pend_reg <= 1'b1;
      pend_data_reg <= shift_next;
    end else if (fifo_ready) begin
      push_pend_reg <= usu_pkg::LOW;
    end
  end

  usu_fifo #(
    .WIDTH(usu_pkg::DATA_W),
    .DEPTH(usu_pkg::FIFO_DEPTH),
    .AW(usu_pkg::FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .s_valid_i(push_pend_reg),
    .s_ready_o(fifo_ready),
    .s_data_i(pend_data_reg),
    .m_valid_o(rx_valid_o),
    .m_ready_i(rx_ready_i),
    .m_data_o(rx_data_o)
  );

  assign serial_shift_register_o = shift_reg;
  assign counter_o = count_reg;
  assign counter_overflow_flag_o = ovf_flag_reg;
  assign start_flag_o = start_flag_reg;
  assign data_out_pin_o = do_reg;
  assign data_out_oe_n_o = do_oe_n_reg;
  assign two_wire_data_o = usu_pkg::LOW;
  assign two_wire_data_oe_n_o = sda_oe_n_reg;
  assign serial_clock_pin_o = sck_pin_reg;
  assign serial_clock_oe_n_o = sck_oe_n_reg;

  data_write_wins_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    data_wr_i |=> shift_reg == $past(data_wdata_i))
    else $error("data write did not win over shift");

  wrap_sets_flag_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (cnt_ev && count_reg == 4'hF && !cnt_wr_i)
    |=> ovf_flag_reg && count_reg == 4'h0)
    else $error("counter wrap did not set flag");

  clear_counter_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ovf_clear_i && !cnt_ev && !cnt_wr_i)
    |=> !ovf_flag_reg && count_reg == 4'h0)
    else $error("flag clear did not clear counter");

  both_edges_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (external_clock_select_i && !software_clock_strobe_bit_i &&
     (sck_rise || sck_fall) && !push_pend_reg && !cnt_wr_i && !ovf_clear_i)
    |=> count_reg == 4'($past(count_reg) + 4'h1))
    else $error("external edge not counted");

  shift_fall_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (external_clock_select_i && !clock_polarity_select_i && sck_fall &&
     !push_pend_reg && !data_wr_i)
    |=> shift_reg == {$past(shift_reg[6:0]), $past(sample_bit_reg)})
    else $error("falling edge did not shift");

  sample_fall_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (external_clock_select_i && clock_polarity_select_i && sck_fall)
    |=> sample_bit_reg == $past(di_sync_reg))
    else $error("falling edge did not sample");

  toggle_pin_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_wr_i && clock_pin_toggle_bit_i) |=> sck_out_reg != $past(sck_out_reg))
    else $error("toggle bit did not invert clock");

  latch_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (external_clock_select_i && !latch_open_reg && !shift_edge)
    |=> out_bit_reg == $past(out_bit_reg))
    else $error("closed latch changed output");

  strobe_input_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (int_shift && !push_pend_reg && !data_wr_i)
    |=> shift_reg[0] == $past(di_sync_reg))
    else $error("shift did not take data input pin");

  wait_state_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (two_wire && start_flag_reg) |=> !sck_oe_n_reg && !sck_pin_reg)
    else $error("start did not hold clock low");

  ovf_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) wrap);
  start_seen_c: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) start_flag_reg);
  stall_seen_c: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) push_pend_reg && !fifo_ready);
  collide_c: cover property (
    @(posedge sys_clk_i) disable iff (rst_i) data_wr_i && shift_ev);
endmodule : usu_unit
